/* shared/avbs_params.svh */
// Offsets, field positions, reset values and bounds of the transmit arbiter
`ifndef AVBS_PARAMS_SVH
`define AVBS_PARAMS_SVH
`define AVBS_OFF_GAIN       8'h00
`define AVBS_OFF_DRAIN      8'h04
`define AVBS_OFF_CTRL       8'h08
`define AVBS_OFF_STATUS     8'h0c
`define AVBS_OFF_CREDIT     8'h10
`define AVBS_OFF_AV_CNT     8'h14
`define AVBS_OFF_PTP_CNT    8'h18
`define AVBS_OFF_LEG_CNT    8'h1c
`define AVBS_CTRL_EN_BIT    0
`define AVBS_CTRL_CLR_BIT   1
`define AVBS_STAT_JUMBO_BIT 0
`define AVBS_STAT_SRC_LSB   2
`define AVBS_STAT_OK_BIT    4
`define AVBS_GAIN_RST       16'h1800
`define AVBS_DRAIN_RST      16'h0800
`define AVBS_CTRL_RST       2'h1
`define AVBS_CREDIT_W       24
`define AVBS_CREDIT_HI      24'sh0fffff
`define AVBS_CREDIT_LO      24'shf00000
`define AVBS_MAX_LEG_BYTES  1522
`endif

/* shared/avbs_pkg.sv */
// Types shared by the transmit arbiter modules
package avbs_pkg;
    typedef enum logic [1:0] {
        AVBS_IDLE,
        AVBS_AV,
        AVBS_PTP,
        AVBS_LEG
    } avbs_src_e;
endpackage

/* rtl/avbs_fifo.sv */
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module avbs_fifo
    import avbs_pkg::*;
#(
    parameter int W     = 10,
    parameter int DEPTH = 16
)(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    logic         full;

    assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge pclk)
    begin
        if (in_valid && !full)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (in_valid && !full)
                wr_q <= wr_q + 1'b1;
            if (out_valid && out_ready)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule // avbs_fifo

/* rtl/avbs_credit.sv */
// Credit accumulator of the shaper, one step per MAC byte slot (cycle with mac_tready high)
`timescale 1ns/1ps
`include "avbs_params.svh"
module avbs_credit
    import avbs_pkg::*;
#(
    parameter int GW = 16
)(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [GW-1:0] gain_rate,
    input  wire logic [GW-1:0] drain_rate,
    input  wire logic          av_queued,
    input  wire logic          av_waiting,
    input  wire logic          byte_fire,
    input  wire logic          byte_is_av,
    output logic signed [`AVBS_CREDIT_W-1:0] credit,
    output logic               credit_ok
);
    localparam int CW = `AVBS_CREDIT_W;
    localparam logic signed [CW-1:0] HI = `AVBS_CREDIT_HI;
    localparam logic signed [CW-1:0] LO = `AVBS_CREDIT_LO;
    logic signed [CW:0] cred_x;
    logic signed [CW:0] gain_x;
    logic signed [CW:0] drain_x;

    // One extra bit so that a step never wraps before it is clamped
    function automatic logic signed [CW-1:0] sat(input logic signed [CW:0] v);
        if (v > $signed({HI[CW-1], HI}))
            return HI;
        else if (v < $signed({LO[CW-1], LO}))
            return LO;
        else
            return v[CW-1:0];
    endfunction

    assign cred_x    = $signed({credit[CW-1], credit});
    assign gain_x    = $signed({{(CW+1-GW){1'b0}}, gain_rate});
    assign drain_x   = $signed({{(CW+1-GW){1'b0}}, drain_rate});
    assign credit_ok = !credit[CW-1];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            credit <= '0;
        else if (!av_queued && credit > 0)
            credit <= '0;
        else if (byte_fire && byte_is_av)
            credit <= sat(cred_x - drain_x);
        else if (byte_fire && av_waiting)
            credit <= sat(cred_x + gain_x);
    end
endmodule // avbs_credit

/* rtl/avbs_arbiter.sv */
// Transmit arbiter: AV, PTP and legacy sources, shaper, APB registers
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`include "avbs_params.svh"
module avbs_arbiter
    import avbs_pkg::*;
#(
    parameter int FIFO_DEPTH    = 16,
    parameter int MAX_LEG_BYTES = `AVBS_MAX_LEG_BYTES
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  av_tdata,
    input  wire logic        av_stream_valid,
    input  wire logic        av_tlast,
    output logic             av_tready,
    input  wire logic [7:0]  ptp_tdata,
    input  wire logic        ptp_tvalid,
    input  wire logic        ptp_tlast,
    output logic             ptp_tready,
    input  wire logic [7:0]  leg_tdata,
    input  wire logic        leg_tvalid,
    input  wire logic        leg_tlast,
    output logic             leg_tready,
    output logic [7:0]       mac_tdata,
    output logic             mac_tvalid,
    output logic             mac_tlast,
    input  wire logic        mac_tready
);
    // =====================================================================
    // Declarations
    localparam int CW = `AVBS_CREDIT_W;
    localparam int LW = $clog2(MAX_LEG_BYTES + 1);
    localparam logic [LW-1:0] LEG_LAST = LW'(MAX_LEG_BYTES - 1);

    avbs_src_e                state_q;
    logic                     park_q;
    logic [15:0]              gain_q;
    logic [15:0]              drain_q;
    logic [1:0]               ctrl_q;
    logic                     jumbo_q;
    logic [LW-1:0]            leg_len_q;
    logic                     leg_drop_q;
    logic [15:0]              av_cnt_q;
    logic [15:0]              ptp_cnt_q;
    logic [15:0]              leg_cnt_q;
    logic [31:0]              prdata_q;
    logic                     pslverr_q;
    logic signed [CW-1:0]     credit;
    logic                     credit_ok;
    logic                     av_go;
    logic                     fin_valid;
    logic                     fin_ready;
    logic [7:0]               fin_data;
    logic                     fin_last;
    logic                     fin_av;
    logic                     fin_fire;
    logic                     leg_cut;
    logic                     fout_valid;
    logic [9:0]               fout_data;
    logic                     mac_fire;
    logic                     apb_acc;
    logic                     apb_wr;
    logic                     mapped;
    logic [31:0]              rd_word;
    logic                     cnt_clr;
    logic                     jumbo_clr;

    // =====================================================================
    // Source choice
    function automatic avbs_src_e pick(input logic en, input logic av,
                                       input logic ok, input logic ptp,
                                       input logic leg);
        if (!en)
            return AVBS_IDLE;
        else if (av && ok)
            return AVBS_AV;
        else if (ptp)
            return AVBS_PTP;
        else if (leg)
            return AVBS_LEG;
        else
            return AVBS_IDLE;
    endfunction

    // Inside a frame AV always runs; at a frame boundary the credit decides
    assign av_go    = !park_q || credit_ok;
    assign fin_fire = fin_valid && fin_ready;
    assign leg_cut  = (leg_len_q == LEG_LAST) && !leg_tlast;

    // =====================================================================
    // Arbiter state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= AVBS_IDLE;
            park_q  <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                AVBS_IDLE:
                begin
                    state_q <= pick(ctrl_q[`AVBS_CTRL_EN_BIT],
                                    av_stream_valid, credit_ok,
                                    ptp_tvalid, leg_tvalid);
                    park_q  <= 1'b0;
                end
                AVBS_AV:
                begin
                    if (fin_fire && fin_last)
                        park_q <= 1'b1;
                    else if (fin_fire)
                        park_q <= 1'b0;
                    if (park_q && !(av_stream_valid && credit_ok))
                    begin
                        state_q <= pick(ctrl_q[`AVBS_CTRL_EN_BIT], 1'b0,
                                        1'b0, ptp_tvalid,
                                        leg_tvalid);
                        park_q  <= 1'b0;
                    end
                end
                AVBS_PTP:
                begin
                    if (fin_fire && fin_last)
                        state_q <= AVBS_IDLE;
                end
                AVBS_LEG:
                begin
                    if (leg_drop_q && leg_tvalid && leg_tlast)
                        state_q <= AVBS_IDLE;
                    else if (fin_fire && fin_last && !leg_cut)
                        state_q <= AVBS_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // Legacy length guard: no jumbo frames, overlong tail is discarded
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            leg_len_q  <= '0;
            leg_drop_q <= 1'b0;
        end
        else if (leg_drop_q)
        begin
            if (leg_tvalid && leg_tlast)
                leg_drop_q <= 1'b0;
        end
        else if (state_q == AVBS_LEG && fin_fire)
        begin
            if (fin_last)
            begin
                leg_len_q  <= '0;
                leg_drop_q <= leg_cut;
            end
            else
                leg_len_q <= leg_len_q + 1'b1;
        end
    end

    // =====================================================================
    // Byte path into the FIFO
    always_comb
    begin
        fin_valid  = 1'b0;
        fin_data   = 8'h00;
        fin_last   = 1'b0;
        fin_av     = 1'b0;
        av_tready  = 1'b0;
        ptp_tready = 1'b0;
        leg_tready = 1'b0;
        unique case (state_q)
            AVBS_IDLE:
            begin
                fin_valid = 1'b0;
            end
            AVBS_AV:
            begin
                fin_valid = av_stream_valid && av_go;
                av_tready = fin_ready && av_go;
                fin_data  = av_tdata;
                fin_last  = av_tlast;
                fin_av    = 1'b1;
            end
            AVBS_PTP:
            begin
                fin_valid  = ptp_tvalid;
                ptp_tready = fin_ready;
                fin_data   = ptp_tdata;
                fin_last   = ptp_tlast;
            end
            AVBS_LEG:
            begin
                if (leg_drop_q)
                    leg_tready = 1'b1;
                else
                begin
                    fin_valid  = leg_tvalid;
                    leg_tready = fin_ready;
                    fin_data   = leg_tdata;
                    fin_last   = leg_tlast || (leg_len_q == LEG_LAST);
                end
            end
        endcase
    end

    // Sixteen bytes of slack toward the MAC; a stalled MAC stalls every source except a legacy tail being discarded
    avbs_fifo #(
        .W     (10),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (fin_valid),
        .in_ready  (fin_ready),
        .in_data   ({fin_av, fin_last, fin_data}),
        .out_valid (fout_valid),
        .out_ready (mac_tready),
        .out_data  (fout_data)
    );

    assign mac_tvalid = fout_valid;
    assign mac_tdata  = fout_data[7:0];
    assign mac_tlast  = fout_data[8];
    assign mac_fire   = fout_valid && mac_tready;

    // =====================================================================
    // Gain per MAC byte slot, so AV blocked on an idle link still recovers
    avbs_credit #(
        .GW (16)
    ) u_credit (
        .pclk       (pclk),
        .presetn    (presetn),
        .gain_rate  (gain_q),
        .drain_rate (drain_q),
        .av_queued  (av_stream_valid || (state_q == AVBS_AV && !park_q)),
        .av_waiting (av_stream_valid && state_q != AVBS_AV &&
                     !(state_q == AVBS_IDLE && credit_ok)),
        .byte_fire  (mac_tready),
        .byte_is_av (mac_fire && fout_data[9]),
        .credit     (credit),
        .credit_ok  (credit_ok)
    );

    // =====================================================================
    // APB register file: zero wait states, error on unmapped offsets
    assign apb_acc   = psel && penable;
    assign apb_wr    = apb_acc && pwrite;
    assign cnt_clr   = apb_wr && paddr == `AVBS_OFF_CTRL &&
                       pwdata[`AVBS_CTRL_CLR_BIT];
    assign jumbo_clr = apb_wr && paddr == `AVBS_OFF_STATUS &&
                       pwdata[`AVBS_STAT_JUMBO_BIT];

    always_comb
    begin
        mapped  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            `AVBS_OFF_GAIN:   rd_word = {16'h0000, gain_q};
            `AVBS_OFF_DRAIN:  rd_word = {16'h0000, drain_q};
            `AVBS_OFF_CTRL:   rd_word = {30'h0000_0000, 1'b0,
                                         ctrl_q[`AVBS_CTRL_EN_BIT]};
            `AVBS_OFF_STATUS:
            begin
                rd_word[`AVBS_STAT_JUMBO_BIT]                = jumbo_q;
                rd_word[`AVBS_STAT_SRC_LSB+1:`AVBS_STAT_SRC_LSB] = state_q;
                rd_word[`AVBS_STAT_OK_BIT]                   = credit_ok;
            end
            `AVBS_OFF_CREDIT: rd_word = 32'(credit);
            `AVBS_OFF_AV_CNT: rd_word = {16'h0000, av_cnt_q};
            `AVBS_OFF_PTP_CNT: rd_word = {16'h0000, ptp_cnt_q};
            `AVBS_OFF_LEG_CNT: rd_word = {16'h0000, leg_cnt_q};
            default:          mapped  = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_q  <= `AVBS_GAIN_RST;
            drain_q <= `AVBS_DRAIN_RST;
            ctrl_q  <= `AVBS_CTRL_RST;
        end
        else if (apb_wr)
        begin
            if (paddr == `AVBS_OFF_GAIN)
                gain_q <= pwdata[15:0];
            if (paddr == `AVBS_OFF_DRAIN)
                drain_q <= pwdata[15:0];
            if (paddr == `AVBS_OFF_CTRL)
                ctrl_q <= {1'b0, pwdata[`AVBS_CTRL_EN_BIT]};
        end
    end

    // Read data is latched in the setup cycle so it stands in the access one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr_q <= !mapped;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = apb_acc && pslverr_q;

    // =====================================================================
    // Status: sticky overlong flag and frame counters; the event beats a clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            jumbo_q <= 1'b0;
        else if (state_q == AVBS_LEG && fin_fire && leg_cut)
            jumbo_q <= 1'b1;
        else if (jumbo_clr)
            jumbo_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            av_cnt_q  <= 16'h0000;
            ptp_cnt_q <= 16'h0000;
            leg_cnt_q <= 16'h0000;
        end
        else
        begin
            if (cnt_clr)
            begin
                av_cnt_q  <= 16'h0000;
                ptp_cnt_q <= 16'h0000;
                leg_cnt_q <= 16'h0000;
            end
            if (fin_fire && fin_last)
            begin
                unique case (state_q)
                    AVBS_AV:  av_cnt_q  <= (cnt_clr ? 16'h0000 : av_cnt_q)
                                           + 16'h0001;
                    AVBS_PTP: ptp_cnt_q <= (cnt_clr ? 16'h0000 : ptp_cnt_q)
                                           + 16'h0001;
                    AVBS_LEG: leg_cnt_q <= (cnt_clr ? 16'h0000 : leg_cnt_q)
                                           + 16'h0001;
                    AVBS_IDLE: ;
                endcase
            end
        end
    end
endmodule // avbs_arbiter

/* verification/avbs_arbiter_assertions.sv */
// Port-level assertions of the transmit arbiter
`timescale 1ns/1ps
module avbs_arbiter_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        av_stream_valid,
    input wire logic        av_tlast,
    input wire logic        av_tready,
    input wire logic        ptp_tvalid,
    input wire logic        ptp_tlast,
    input wire logic        ptp_tready,
    input wire logic        leg_tvalid,
    input wire logic        leg_tlast,
    input wire logic        leg_tready,
    input wire logic [7:0]  mac_tdata,
    input wire logic        mac_tvalid,
    input wire logic        mac_tlast,
    input wire logic        mac_tready
);
    // =====
    // Stream grants and MAC output hold
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic av_hs, ptp_hs, leg_hs;
    assign av_hs  = av_tready && av_stream_valid;
    assign ptp_hs = ptp_tready && ptp_tvalid;
    assign leg_hs = leg_tready && leg_tvalid;
    a_one_grant:
        assert property ($onehot0({av_tready, ptp_tready, leg_tready}))
        else $error("two sources granted");
    a_av_whole:
        assert property (av_hs && !av_tlast |=> !ptp_tready && !leg_tready)
        else $error("AV frame interrupted");
    a_leg_whole:
        assert property (leg_hs && !leg_tlast |=> !av_tready && !ptp_tready)
        else $error("legacy frame interrupted");
    a_av_end_next:
        assert property (av_hs && av_tlast |=> !ptp_tready && !leg_tready)
        else $error("other source granted right after AV end");
    a_leg_end_gap:
        assert property (leg_hs && leg_tlast
                         |=> !(av_tready || ptp_tready || leg_tready))
        else $error("no idle cycle after legacy frame");
    a_ptp_end_gap:
        assert property (ptp_hs && ptp_tlast
                         |=> !(av_tready || ptp_tready || leg_tready))
        else $error("no idle cycle after PTP frame");
    a_mac_hold:
        assert property (mac_tvalid && !mac_tready |=> mac_tvalid
                         && $stable(mac_tdata) && $stable(mac_tlast))
        else $error("MAC byte changed while stalled");
    // =====
    // Register bus
    a_apb_no_wait:
        assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_bad_addr:
        assert property (psel && penable && !pwrite && paddr > 8'h1c
                         |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_err_access:
        assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
endmodule // avbs_arbiter_assertions

/* verification/avbs_src_model.sv */
// Frame source model standing in for one user stream
`timescale 1ns/1ps
module avbs_src_model #(
    parameter logic [1:0] TAG = 2'h0
)(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic [7:0] frames,
    input  wire logic [7:0] len,
    input  wire logic       tready,
    output logic [7:0]      tdata,
    output logic            tvalid,
    output logic            tlast
);
    // =====
    // Byte generator
    logic [7:0] left_q;
    logic [7:0] idx_q;
    // Idle bus shows the inverse, so a stale byte cannot pass
    assign tdata = tvalid ? {TAG, idx_q[5:0]} : ~idx_q;
    assign tlast = tvalid && (idx_q == len - 8'h01);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            left_q <= 8'h00;
            idx_q  <= 8'h00;
            tvalid <= 1'b0;
        end
        else if (go && !tvalid)
        begin
            left_q <= frames;
            idx_q  <= 8'h00;
            tvalid <= (frames != 8'h00);
        end
        else if (tvalid && tready)
        begin
            idx_q <= tlast ? 8'h00 : idx_q + 8'h01;
            if (tlast)
            begin
                left_q <= left_q - 8'h01;
                tvalid <= (left_q > 8'h01);
            end
        end
    end
endmodule // avbs_src_model

/* verification/avbs_arbiter_tb.sv */
// Self-checking bench of the transmit arbiter
`timescale 1ns/1ps
`include "avbs_params.svh"
module avbs_arbiter_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, av_tdata, ptp_tdata, leg_tdata, mac_tdata;
    logic [31:0] pwdata, prdata, r;
    logic        av_stream_valid, av_tlast, av_tready, e;
    logic        ptp_tvalid, ptp_tlast, ptp_tready;
    logic        leg_tvalid, leg_tlast, leg_tready;
    logic        mac_tvalid, mac_tlast, mac_tready, stall_en;
    logic [2:0]  go;
    logic [7:0]  fr[3], ln[3];
    logic [1:0]  src_q, prev_q = 2'h3, order_q[$];
    logic        sof_q = 1'b1, av_end_q, park_chk, alt_chk;
    int          nout[4], err_count, n_checks, p;
    avbs_arbiter dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .av_tdata, .av_stream_valid,
        .av_tlast, .av_tready, .ptp_tdata, .ptp_tvalid, .ptp_tlast,
        .ptp_tready, .leg_tdata, .leg_tvalid, .leg_tlast, .leg_tready,
        .mac_tdata, .mac_tvalid, .mac_tlast, .mac_tready);
    avbs_src_model #(.TAG(2'h0)) u_av (.pclk, .presetn, .go(go[0]),
        .frames(fr[0]), .len(ln[0]), .tready(av_tready),
        .tdata(av_tdata), .tvalid(av_stream_valid), .tlast(av_tlast));
    avbs_src_model #(.TAG(2'h1)) u_ptp (.pclk, .presetn, .go(go[1]),
        .frames(fr[1]), .len(ln[1]), .tready(ptp_tready),
        .tdata(ptp_tdata), .tvalid(ptp_tvalid), .tlast(ptp_tlast));
    avbs_src_model #(.TAG(2'h2)) u_leg (.pclk, .presetn, .go(go[2]),
        .frames(fr[2]), .len(ln[2]), .tready(leg_tready),
        .tdata(leg_tdata), .tvalid(leg_tvalid), .tlast(leg_tlast));
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // =====
    // Helpers
    function automatic logic [31:0] slope(int pct, bit gain);
        return gain ? 32'(pct * 8192 / 100) : 32'((100 - pct) * 8192 / 100);
    endfunction
    function automatic logic [31:0] cred(int v);
        return 32'(v < -1048576 ? -1048576 : (v > 1048575 ? 1048575 : v));
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    task automatic load(input logic [2:0] m, input logic [7:0] nf,
                        input logic [7:0] l);
        for (int i = 0; i < 3; i++)
            if (m[i])
            begin
                fr[i] <= nf;
                ln[i] <= l;
            end
        go <= m;
        @(posedge pclk);
        go <= 3'h0;
        @(posedge pclk);
    endtask
    task automatic wait_out(input int total);
        int n;
        n = 0;
        while (nout[0] + nout[1] + nout[2] < total && n < 20000)
        begin
            @(posedge pclk);
            n++;
        end
        repeat (4) @(posedge pclk);
        chk(32'(nout[0] + nout[1] + nout[2]), 32'(total));
    endtask
    task automatic tstart();
        nout = '{default: 0};
        order_q.delete();
    endtask
    // =====
    // MAC sink with random stalls, frame monitor
    always @(posedge pclk)
    begin
        mac_tready <= stall_en ? ($urandom_range(3) != 0) : 1'b1;
        av_end_q <= av_tready && av_stream_valid && av_tlast;
        if (park_chk && av_end_q && av_stream_valid)
            chk({31'h0, av_tready}, 32'h1);
        if (mac_tvalid && mac_tready)
        begin
            if (sof_q)
                src_q = mac_tdata[7:6];
            sof_q = mac_tlast;
            if (mac_tlast)
            begin
                if (alt_chk && src_q == 2'h0)
                    chk({31'h0, prev_q == 2'h0}, 32'h0);
                prev_q = src_q;
                nout[src_q]++;
                order_q.push_back(src_q);
            end
        end
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        $display("mismatch t=%0t watchdog expired", $time);
        close_out();
    end
    // =====
    // Scenarios
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {stall_en, park_chk, alt_chk} = 3'b000;
        go = 3'h0;
        fr = '{default: 8'h00};
        ln = '{default: 8'h01};
        err_count = 0;
        n_checks = 0;
        tstart();
        void'($urandom(74022));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`AVBS_OFF_GAIN, 32'd6144);
        rd(`AVBS_OFF_DRAIN, 32'd2048);
        rd(`AVBS_OFF_CREDIT, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test registers done");
        load(3'b111, 8'h01, 8'h08);
        wait_out(3);
        chk({26'h0, order_q[0], order_q[1], order_q[2]}, 32'h06);
        rd(`AVBS_OFF_CREDIT, cred(-8 * 2048));
        rd(`AVBS_OFF_AV_CNT, 32'h1);
        $display("test priority done");
        for (int i = 0; i < 4; i++)
        begin
            p = (i == 3) ? 75 : $urandom_range(75, 1);
            apb(1'b1, `AVBS_OFF_GAIN, slope(p, 1'b1));
            apb(1'b1, `AVBS_OFF_DRAIN, slope(p, 1'b0));
            rd(`AVBS_OFF_GAIN, slope(p, 1'b1));
            rd(`AVBS_OFF_DRAIN, slope(p, 1'b0));
        end
        $display("test slopes done");
        tstart();
        park_chk <= 1'b1;
        load(3'b100, 8'h01, 8'd200);
        repeat (5) @(posedge pclk);
        load(3'b001, 8'h03, 8'h08);
        wait_out(4);
        park_chk <= 1'b0;
        chk(32'(nout[0]), 32'd3);
        rd(`AVBS_OFF_CREDIT, 32'h0);
        $display("test parking done");
        tstart();
        apb(1'b1, `AVBS_OFF_GAIN, 32'h0800);
        apb(1'b1, `AVBS_OFF_DRAIN, 32'h1800);
        stall_en <= 1'b1;
        alt_chk <= 1'b1;
        load(3'b100, 8'd28, 8'd32);
        load(3'b001, 8'd4, 8'd48);
        wait_out(32);
        chk(32'(nout[0]), 32'd4);
        stall_en <= 1'b0;
        alt_chk <= 1'b0;
        $display("test shaping done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        tstart();
        rd(`AVBS_OFF_DRAIN, 32'd2048);
        apb(1'b1, `AVBS_OFF_DRAIN, 32'h0000ffff);
        load(3'b001, 8'h01, 8'd20);
        wait_out(1);
        rd(`AVBS_OFF_CREDIT, cred(-20 * 65535));
        $display("test lower bound done");
        close_out();
    end
endmodule // avbs_arbiter_tb
bind avbs_arbiter avbs_arbiter_assertions u_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .av_stream_valid,
    .av_tlast, .av_tready, .ptp_tvalid, .ptp_tlast, .ptp_tready, .leg_tvalid,
    .leg_tlast, .leg_tready, .mac_tdata, .mac_tvalid, .mac_tlast,
    .mac_tready);
